// ---- pe_deskew_pkg.sv ----
// Constants shared by the phase-encoded read detector and skew buffer.
// Assumes one read clock that oversamples each character cell 24 times.
package pe_deskew_pkg;

   // -------------------------------------------------------------------
   // Geometry
   // -------------------------------------------------------------------
   localparam int         NUM_TRACKS      = 9;      // Eight data tracks and parity
   localparam int         NUM_SLOTS       = 10;     // Nine tracks plus the frame slot
   localparam int         DEPTH           = 4;      // Locations per track
   localparam int         CNT_W           = 5;      // Drop counter width

   // -------------------------------------------------------------------
   // Slot codes
   // -------------------------------------------------------------------
   localparam logic [3:0] SLOT_FIRST      = 4'h0;
   localparam logic [3:0] SLOT_PARITY     = 4'h8;
   localparam logic [3:0] SLOT_FRAME      = 4'h9;

   // -------------------------------------------------------------------
   // Timing and address values
   // -------------------------------------------------------------------
   localparam int         CLOCKS_PER_CELL = 24;     // Read clocks per character cell
   localparam logic [4:0] GATE_OPEN       = 5'(CLOCKS_PER_CELL * 3 / 4);
   localparam logic [4:0] DROP_COUNT      = 5'h1f;  // Silence count marking a drop
   localparam logic [1:0] ADDR_FIRST      = 2'h0;
   localparam logic [1:0] ADDR_LAST       = 2'h3;

   typedef logic [3:0] slot_t;

endpackage

// ---- pe_read_deskew.sv ----
// Read-side transition detectors and ten-slot skew buffer for nine tracks.
// Assumes core_clk is the oversampled read clock and that track inputs come
// straight from pins; control inputs come from logic on the same clock.
//
// Behaviour
// - After marker, pass only gated data transitions
// - Gated transition sets ready, captures polarity
// - Flags sampled and cleared in own slot
// - No ready before preamble end marker
// - Dropped channel blocked in block, stalls until block or record end
// - Drop flag steers correction, zeroes output bit
// - Skew buffer FIFO with ten slots
// - Entry and readout coexist in a frame
// - One-clock entry strobe; bit meaningless otherwise
// - Forward motion inverts stored data
// - Four ten-bit recirculating data registers
// - Entry shifts onward, new bit first
// - Two-bit address per slot, increments on entry
// - Cleared until enable; first entry location 0
// - Address 3 wraps on entry, signals full
// - Full latched, readout next frame period
// - Slot counter: tracks 0-7, parity, frame
// - Detectors clocked by oversampled read clock
// - Marker seen as missing phase transition
// - Readout decrements address; both leave unchanged
`timescale 1ns/1ps
`default_nettype none

module pe_read_deskew (
   input  wire logic       core_clk,                 // Oversampled read clock
   input  wire logic       resetn,                   // Asynchronous reset, active low
   input  wire logic [8:0] track_in,                 // Raw track read data pins
   input  wire logic       read_capture_enable,      // Record in progress
   input  wire logic       block_present,            // Block detected
   input  wire logic       reverse_motion,           // Tape moving in reverse
   output logic      [8:0] expected_transition_gate, // Data transition window
   output logic      [8:0] marker_seen,              // Preamble end found per track
   output logic      [8:0] channel_bit_ready,        // Recovered bit waiting
   output logic      [8:0] channel_bit_value,        // Recovered bit polarity
   output logic      [8:0] channel_drop_flag,        // Track dropped out
   output logic      [3:0] slot_index,               // Current slot
   output logic            parity_slot_select,       // Parity slot now
   output logic            frame_slot_select,        // Frame slot now
   output logic            slot_entry_strobe,        // Bit entered this slot
   output logic            deskew_input_bit,         // Bit being entered
   output logic            deskew_full_flag,         // Track buffer just filled
   output logic            readout_active,           // Character readout frame
   output logic            deskew_output_bit,        // Bit read out last slot
   output logic      [3:0] output_slot               // Slot of deskew_output_bit
);

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   logic [8:0] sync_a;                    // First synchroniser stage
   logic [8:0] sync_b;                    // Second synchroniser stage
   logic [8:0] sync_c;                    // Delayed copy for edge detection
   logic [8:0] edge_pulse;
   logic [8:0] data_pulse;
   logic [4:0] silence [pe_deskew_pkg::NUM_TRACKS];
   logic [9:0] sb_data [pe_deskew_pkg::DEPTH];
   logic [9:0] sb_addr_lo;
   logic [9:0] sb_addr_hi;
   logic [1:0] head_addr;
   logic [1:0] next_addr;
   logic       head_drop;
   logic       track_slot;
   logic       take_out;
   logic       full_latch;
   logic       next_out_bit;

   // True for slots that carry a tape track
   function automatic logic is_track(input pe_deskew_pkg::slot_t s);
      is_track = (s < pe_deskew_pkg::SLOT_FRAME);
   endfunction

   // -------------------------------------------------------------------
   // Slot counter
   // -------------------------------------------------------------------
   // Advances every read clock and folds back after the frame slot
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         slot_index <= pe_deskew_pkg::SLOT_FIRST;
      end else if (slot_index == pe_deskew_pkg::SLOT_FRAME) begin
         slot_index <= pe_deskew_pkg::SLOT_FIRST;
      end else begin
         slot_index <= slot_index + 4'h1;
      end
   end

   assign parity_slot_select = (slot_index == pe_deskew_pkg::SLOT_PARITY);
   assign frame_slot_select  = (slot_index == pe_deskew_pkg::SLOT_FRAME);
   assign track_slot         = is_track(slot_index);

   // -------------------------------------------------------------------
   // Track input synchronisers and edge detection
   // -------------------------------------------------------------------
   // Two stages against metastability, a third to find transitions
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= 9'h000;
         sync_b <= 9'h000;
         sync_c <= 9'h000;
      end else begin
         sync_a <= track_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   assign edge_pulse = sync_b ^ sync_c;

   // -------------------------------------------------------------------
   // Per-track detectors
   // -------------------------------------------------------------------
   genvar t;
   generate
      for (t = 0; t < pe_deskew_pkg::NUM_TRACKS; t++) begin : g_det
         logic pass;
         logic blocked;

         // A dropped track inside a block no longer sees transitions
         assign blocked = block_present && channel_drop_flag[t];
         assign expected_transition_gate[t] = marker_seen[t] &&
                                              (silence[t] >= pe_deskew_pkg::GATE_OPEN);
         // Before the marker every edge restarts the count; after it only gated ones
         assign pass = edge_pulse[t] && !blocked &&
                       (!marker_seen[t] || expected_transition_gate[t]);
         // Gated by the record so no flag can be set while the marker is clearing
         assign data_pulse[t] = edge_pulse[t] && marker_seen[t] &&
                                expected_transition_gate[t] && !blocked &&
                                read_capture_enable;
         assign channel_drop_flag[t] = (silence[t] == pe_deskew_pkg::DROP_COUNT);

         // Silence counter, saturating at the drop count
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               silence[t] <= 5'h00;
            end else if (!read_capture_enable) begin
               silence[t] <= 5'h00;
            end else if (pass) begin
               silence[t] <= 5'h00;
            end else if (silence[t] != pe_deskew_pkg::DROP_COUNT) begin
               silence[t] <= silence[t] + 5'h01;
            end
         end

         // A missing phase transition lets the window open for the first time
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               marker_seen[t] <= 1'b0;
            end else if (!read_capture_enable) begin
               marker_seen[t] <= 1'b0;
            end else if (!marker_seen[t] && silence[t] >= pe_deskew_pkg::GATE_OPEN) begin
               marker_seen[t] <= 1'b1;
            end
         end

         // Ready and bit flags; a new transition beats the slot clear
         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               channel_bit_ready[t] <= 1'b0;
               channel_bit_value[t] <= 1'b0;
            end else if (!read_capture_enable) begin
               channel_bit_ready[t] <= 1'b0;
               channel_bit_value[t] <= 1'b0;
            end else if (data_pulse[t]) begin
               channel_bit_ready[t] <= 1'b1;
               channel_bit_value[t] <= sync_b[t];
            end else if (slot_index == 4'(t)) begin
               channel_bit_ready[t] <= 1'b0;
               channel_bit_value[t] <= 1'b0;
            end
         end

         a_flag_slot_clear : assert property (@(posedge core_clk) disable iff (!resetn)
            slot_index == 4'(t) |=> channel_bit_ready[t] == $past(data_pulse[t]))
            else $error("ready flag not cleared in own slot");
      end
   endgenerate

   // -------------------------------------------------------------------
   // Entry multiplexer
   // -------------------------------------------------------------------
   // One strobe per track slot holding a bit; frame slot counts as dropped
   assign slot_entry_strobe = read_capture_enable && track_slot &&
                              channel_bit_ready[slot_index];
   assign deskew_input_bit  = track_slot &&
                              (channel_bit_value[slot_index] ^ !reverse_motion);
   assign head_drop         = !track_slot || channel_drop_flag[slot_index];

   // -------------------------------------------------------------------
   // Skew buffer address arithmetic
   // -------------------------------------------------------------------
   assign head_addr        = {sb_addr_hi[0], sb_addr_lo[0]};
   assign take_out         = readout_active && !head_drop;
   // Entry adds one, readout takes one; both together leave it unchanged
   assign next_addr        = head_addr + {1'b0, slot_entry_strobe} - {1'b0, take_out};
   assign deskew_full_flag = slot_entry_strobe && !head_drop &&
                             (head_addr == pe_deskew_pkg::ADDR_LAST);

   // -------------------------------------------------------------------
   // Skew buffer storage
   // -------------------------------------------------------------------
   // Registers rotate one place per clock so bit 0 is always the current slot
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sb_addr_lo <= 10'h000;
         sb_addr_hi <= 10'h000;
      end else if (!read_capture_enable) begin
         sb_addr_lo <= 10'h000;
         sb_addr_hi <= 10'h000;
      end else begin
         sb_addr_lo <= {next_addr[0], sb_addr_lo[9:1]};
         sb_addr_hi <= {next_addr[1], sb_addr_hi[9:1]};
      end
   end

   genvar k;
   generate
      for (k = 0; k < pe_deskew_pkg::DEPTH; k++) begin : g_sb
         logic head_new;

         // Location 0 takes the new bit; others take the one before; last is lost
         if (k == 0) begin : g_first
            assign head_new = slot_entry_strobe ? deskew_input_bit : sb_data[0][0];
         end else begin : g_rest
            assign head_new = slot_entry_strobe ? sb_data[k-1][0] : sb_data[k][0];
         end

         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               sb_data[k] <= 10'h000;
            end else if (!read_capture_enable) begin
               sb_data[k] <= 10'h000;
            end else begin
               sb_data[k] <= {head_new, sb_data[k][9:1]};
            end
         end
      end
   endgenerate

   // -------------------------------------------------------------------
   // Full latch and readout frame
   // -------------------------------------------------------------------
   // Any track filling during a frame forces one character out next frame
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         full_latch     <= 1'b0;
         readout_active <= 1'b0;
      end else if (!read_capture_enable) begin
         full_latch     <= 1'b0;
         readout_active <= 1'b0;
      end else if (frame_slot_select) begin
         full_latch     <= 1'b0;
         readout_active <= full_latch;
      end else if (deskew_full_flag) begin
         full_latch     <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Readout bit
   // -------------------------------------------------------------------
   // Oldest bit sits one below the next write address; dropped tracks read zero.
   // Address 0 on a readout means all four locations are held: location 3 is read.
   always_comb begin
      next_out_bit = 1'b0;
      if (take_out) begin
         next_out_bit = sb_data[head_addr - 2'h1][0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         deskew_output_bit <= 1'b0;
         output_slot       <= pe_deskew_pkg::SLOT_FIRST;
      end else begin
         deskew_output_bit <= next_out_bit;
         output_slot       <= slot_index;
      end
   end

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   a_ready_after_mark : assert property ((channel_bit_ready & ~marker_seen) == 9'h000)
      else $error("ready flag without marker");
   a_strobe_has_bit : assert property (slot_entry_strobe |->
      track_slot && channel_bit_ready[slot_index])
      else $error("entry strobe without waiting bit");
   a_slot_wraps : assert property (frame_slot_select |=> slot_index == 4'h0)
      else $error("slot counter did not fold after frame");
   a_drop_stalls : assert property (read_capture_enable && block_present ##1
      read_capture_enable |-> (channel_drop_flag & $past(channel_drop_flag)) ==
      $past(channel_drop_flag))
      else $error("dropped track recovered inside block");
   a_cleared_idle : assert property (!read_capture_enable |=>
      sb_addr_lo == 10'h000 && sb_addr_hi == 10'h000 && sb_data[0] == 10'h000)
      else $error("skew buffer not held clear");
   a_entry_shift : assert property (slot_entry_strobe |=>
      sb_data[0][9] == $past(deskew_input_bit) && sb_data[1][9] == $past(sb_data[0][0]))
      else $error("entry did not shift in new bit");
   a_recirculate : assert property (read_capture_enable && !slot_entry_strobe && !take_out
      ##1 read_capture_enable |-> sb_data[3][9] == $past(sb_data[3][0]) &&
      {sb_addr_hi[9], sb_addr_lo[9]} == $past(head_addr))
      else $error("idle slot changed while recirculating");
   a_full_wraps : assert property (deskew_full_flag && !readout_active
      ##1 read_capture_enable |-> {sb_addr_hi[9], sb_addr_lo[9]} == 2'h0)
      else $error("address did not wrap on full");
   a_readout_frame : assert property (frame_slot_select && full_latch &&
      read_capture_enable ##1 read_capture_enable [*8] |-> readout_active [*1])
      else $error("readout did not follow full");
   a_both_unchanged : assert property (slot_entry_strobe && take_out
      ##1 read_capture_enable |-> {sb_addr_hi[9], sb_addr_lo[9]} == $past(head_addr))
      else $error("address moved on entry with readout");
   a_drop_reads_zero : assert property (readout_active && head_drop |=> !deskew_output_bit)
      else $error("dropped slot read out non-zero");

   c_full : cover property (deskew_full_flag);
   c_readout : cover property (!readout_active ##1 readout_active);
   c_drop : cover property (!channel_drop_flag[0] ##1 channel_drop_flag[0]);
   c_both : cover property (slot_entry_strobe && take_out);

endmodule

`default_nettype wire

// ---- pe_track_model.sv ----
// Behavioural model of the nine tape read channels that feed the block.
// Assumes send rises together with read_capture_enable; a cell is 24 clocks.
`timescale 1ns/1ps
`default_nettype none

module pe_track_model #(
   parameter int PRE = 6                   // Preamble zero cells, shortened
) (
   input  wire logic       core_clk,       // Read clock
   input  wire logic       resetn,         // Asynchronous reset, active low
   input  wire logic       send,           // Record being played
   input  wire logic [8:0] next_char,      // Character for the next cell
   input  wire logic [8:0] silence_mask,   // Tracks that stop transitioning
   output logic      [8:0] track_in,       // Track levels
   output logic            bit_sent,       // Data transition just launched
   output logic      [8:0] sent_char       // Character of that transition
);
   logic [4:0] phase;
   logic [3:0] ncell;
   logic [8:0] cur;
   logic [8:0] pick;

   // Preamble zeros, then an all-ones cell with no phase transition before it
   assign pick = (ncell < 4'(PRE)) ? 9'h000 : (ncell == 4'(PRE)) ? 9'h1ff : next_char;

   // Boundary sets the level opposite to the bit, mid cell sets the bit itself
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         phase     <= 5'h00;
         ncell     <= 4'h0;
         cur       <= 9'h000;
         track_in  <= 9'h000;
         bit_sent  <= 1'b0;
         sent_char <= 9'h000;
      end else if (!send) begin
         phase    <= 5'h00;
         ncell    <= 4'h0;
         bit_sent <= 1'b0;
      end else begin
         phase    <= (phase == 5'h17) ? 5'h00 : phase + 5'h01;
         bit_sent <= 1'b0;
         if (phase == 5'h00) begin
            cur      <= pick;
            track_in <= (track_in & silence_mask) | (~pick & ~silence_mask);
            if (ncell <= 4'(PRE)) begin
               ncell <= ncell + 4'h1;
            end
         end
         if (phase == 5'h0c) begin
            track_in  <= (track_in & silence_mask) | (cur & ~silence_mask);
            bit_sent  <= (ncell > 4'(PRE));
            sent_char <= cur;
         end
      end
   end
endmodule

`default_nettype wire

// ---- pe_read_deskew_tb.sv ----
// Self-checking bench for the read detectors and skew buffer.
// Assumes pe_track_model plays records; expectations come from a queue model.
`timescale 1ns/1ps
`default_nettype none

module pe_read_deskew_tb;
   logic       core_clk, resetn, read_capture_enable, block_present, reverse_motion, send;
   logic [8:0] next_char, silence_mask, track_in, sent_char, expected_transition_gate;
   logic [8:0] marker_seen, channel_bit_ready, channel_bit_value, channel_drop_flag;
   logic [3:0] slot_index, output_slot, pend_s, t;
   logic       parity_slot_select, frame_slot_select, slot_entry_strobe, deskew_input_bit;
   logic       deskew_full_flag, readout_active, deskew_output_bit, bit_sent;
   logic       pend_v, pend_b, latch, exp_ro, frame_seen, got_marker, eb;
   logic       sentq [0:8][$];
   logic       stored [0:8][$];
   logic [8:0] corner [0:2] = '{9'h000, 9'h1ff, 9'h155};
   int         fails, compares, seed, ncell, cnt, w, gap;

   // Clock at 200 MHz
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;

   pe_read_deskew u_pe_read_deskew (.core_clk(core_clk), .resetn(resetn), .track_in(track_in),
      .read_capture_enable(read_capture_enable), .block_present(block_present),
      .reverse_motion(reverse_motion), .expected_transition_gate(expected_transition_gate),
      .marker_seen(marker_seen), .channel_bit_ready(channel_bit_ready),
      .channel_bit_value(channel_bit_value), .channel_drop_flag(channel_drop_flag),
      .slot_index(slot_index), .parity_slot_select(parity_slot_select),
      .frame_slot_select(frame_slot_select), .slot_entry_strobe(slot_entry_strobe),
      .deskew_input_bit(deskew_input_bit), .deskew_full_flag(deskew_full_flag),
      .readout_active(readout_active), .deskew_output_bit(deskew_output_bit),
      .output_slot(output_slot));

   pe_track_model u_pe_track_model (.core_clk(core_clk), .resetn(resetn), .send(send),
      .next_char(next_char), .silence_mask(silence_mask), .track_in(track_in),
      .bit_sent(bit_sent), .sent_char(sent_char));

   // Compare tasks and closing report
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t %s got %b exp %b", $time, msg, got, exp);
      end
   endtask

   task automatic chk_vec(input logic [8:0] got, input logic [8:0] exp, input string msg);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic test_done;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // -------------------------------------------------------------------
   // Characters: corner cases first, then random
   // -------------------------------------------------------------------
   always @(posedge core_clk) begin
      if (bit_sent) begin
         next_char <= (ncell < 3) ? corner[ncell] : 9'($random(seed));
         ncell     <= ncell + 1;
      end
   end

   // Queue model of entries, full flags and readouts, sampled mid cycle
   always @(negedge core_clk) begin
      if (!resetn || !read_capture_enable) begin
         pend_v = 1'b0; latch = 1'b0; frame_seen = 1'b0; got_marker = 1'b0;
         gap = 100;
         for (int i = 0; i < 9; i++) begin
            sentq[i].delete();
            stored[i].delete();
         end
      end else begin
         if (pend_v) begin
            chk_bit(deskew_output_bit, pend_b, "readout bit");
            chk_vec({5'h00, output_slot}, {5'h00, pend_s}, "readout slot");
         end else begin
            chk_bit(deskew_output_bit, 1'b0, "idle output");
         end
         pend_v = 1'b0;
         if (!got_marker) chk_vec(channel_bit_ready, 9'h000, "ready before marker");
         if (slot_index == 4'h0 && frame_seen) chk_bit(readout_active, exp_ro, "readout");
         if (slot_entry_strobe) begin
            t   = slot_index;
            cnt = stored[t].size();
            if (sentq[t].size() == 0) chk_bit(1'b1, 1'b0, "entry without data");
            else eb = sentq[t].pop_front() ^ ~reverse_motion;
            chk_bit(deskew_input_bit, eb, "entry bit");
            chk_bit(deskew_full_flag, cnt == 3, "full flag");
            if (cnt == 3) latch = 1'b1;
         end else chk_bit(deskew_full_flag, 1'b0, "full without entry");
         if (readout_active) begin
            pend_v = 1'b1;
            pend_s = slot_index;
            pend_b = 1'b0;
            if (slot_index < 4'h9 && !channel_drop_flag[slot_index]
                && stored[slot_index].size() > 0) pend_b = stored[slot_index].pop_front();
         end
         if (slot_entry_strobe) stored[t].push_back(eb);
         if (slot_index == 4'h9) begin
            exp_ro = latch;
            latch = 1'b0;
            frame_seen = 1'b1;
         end
         // Halfway to the next data transition only dropped tracks keep the gate open
         if (gap < 100) gap++;
         if (gap == 12) begin
            chk_vec(expected_transition_gate, channel_drop_flag, "gate closed");
         end
         if (bit_sent) begin
            gap = 0;
            chk_vec(marker_seen, 9'h1ff, "marker seen");
            chk_vec(expected_transition_gate, 9'h1ff, "gate open");
            got_marker = 1'b1;
            for (int i = 0; i < 9; i++) if (!silence_mask[i]) sentq[i].push_back(sent_char[i]);
         end
      end
   end

   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      seed = 32'h0155; ncell = 0; fails = 0; compares = 0;
      resetn = 1'b0; read_capture_enable = 1'b0; block_present = 1'b0;
      reverse_motion = 1'b0; send = 1'b0; next_char = 9'h000; silence_mask = 9'h000;
      repeat (3) @(posedge core_clk);
      chk_vec({5'h00, slot_index}, 9'h000, "reset slot");
      chk_vec(channel_bit_ready, 9'h000, "reset ready");
      resetn <= 1'b1;
      for (int i = 0; i < 20; i++) begin
         @(negedge core_clk);
         chk_vec({5'h00, slot_index}, 9'(i % 10), "slot count");
         chk_bit(parity_slot_select, i % 10 == 8, "parity slot");
         chk_bit(frame_slot_select, i % 10 == 9, "frame slot");
      end
      // Forward record, then a track drops out under block detect
      @(posedge core_clk);
      reverse_motion <= 1'b0; read_capture_enable <= 1'b1; send <= 1'b1;
      repeat (300) @(posedge core_clk);
      block_present <= 1'b1;
      silence_mask  <= 9'h008;
      for (w = 0; w < 80 && channel_drop_flag[3] !== 1'b1; w++) @(negedge core_clk);
      chk_vec(channel_drop_flag, 9'h008, "drop flag");
      @(posedge core_clk);
      silence_mask <= 9'h000;
      repeat (200) @(negedge core_clk);
      chk_vec(channel_drop_flag, 9'h008, "drop held");
      chk_bit(channel_bit_ready[3], 1'b0, "dropped track blocked");
      @(posedge core_clk);
      read_capture_enable <= 1'b0; send <= 1'b0; block_present <= 1'b0;
      repeat (20) @(negedge core_clk);
      chk_vec(channel_drop_flag, 9'h000, "record end");
      // Reverse record stores bits as read
      @(posedge core_clk);
      reverse_motion <= 1'b1; read_capture_enable <= 1'b1; send <= 1'b1;
      repeat (500) @(posedge core_clk);
      test_done();
   end
endmodule

`default_nettype wire
